// ===== design/mdiosm_top.sv
// MDIO station management master behind an AXI4-Lite register slave.
//
// The address map and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`include "mdiosm_regs.svh"
module mdiosm_top (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [31:0]          s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output mdiosm_pkg::mdiosm_resp_t  s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [31:0]          s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output mdiosm_pkg::mdiosm_resp_t  s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  output logic                      mdc,
  input  wire logic                 mdio_i,
  output logic                      mdio_o,
  output logic                      mdio_t_n
);
  import mdiosm_pkg::*;

  logic [`MDIOSM_ADDR_W-1:0] aw_addr_ff;
  logic                      aw_full_ff;
  logic [31:0]               w_data_ff;
  logic                      w_full_ff;
  logic [5:0]                div_ff;
  logic                      en_ff;
  logic [1:0]                op_ff;
  logic [4:0]                prt_ff;
  logic [4:0]                dev_ff;
  logic [15:0]               txd_ff;
  logic [15:0]               rxd_ff;
  logic [15:0]               rx_sh_ff;
  logic [63:0]               frame_ff;
  logic [6:0]                cnt_ff;
  mdiosm_state_t             state_ff;
  logic                      busy;
  logic                      is_read;
  logic                      do_write;
  logic                      start;
  logic                      wr_cfg1;
  logic                      mdio_sync;
  logic                      mdc_int;
  logic                      rise_p;
  logic                      fall_p;
  logic [31:0]               nxt_rdata;
  mdiosm_resp_t              nxt_bresp;
  mdiosm_resp_t              nxt_rresp;
  logic [`MDIOSM_ADDR_W-1:0] ar_addr;

  assign busy    = (state_ff != MDIOSM_IDLE);
  assign is_read = op_ff[1];

  // Address and data are taken in either order; the response waits for both.
  assign s_axi_awready = !aw_full_ff;
  assign s_axi_wready  = !w_full_ff;
  assign do_write = aw_full_ff && w_full_ff && !s_axi_bvalid;
  assign wr_cfg1  = do_write && (aw_addr_ff == `MDIOSM_OFF_CFG1);
  // Initiate only counts when enabled and ready.
  assign start = wr_cfg1 && !busy && en_ff && w_data_ff[`MDIOSM_B_INIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_ff <= 1'b0;
      aw_addr_ff <= '0;
    end else if (s_axi_awvalid && !aw_full_ff) begin
      aw_full_ff <= 1'b1;
      aw_addr_ff <= s_axi_awaddr[`MDIOSM_ADDR_W-1:0];
    end else if (do_write) begin
      aw_full_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_ff <= 1'b0;
      w_data_ff <= '0;
    end else if (s_axi_wvalid && !w_full_ff) begin
      w_full_ff <= 1'b1;
      w_data_ff <= s_axi_wdata;
    end else if (do_write) begin
      w_full_ff <= 1'b0;
    end
  end

  // A busy station refuses command changes, so those writes fail.
  always_comb begin
    case (aw_addr_ff)
      `MDIOSM_OFF_CFG0: nxt_bresp = `MDIOSM_RESP_OK;
      `MDIOSM_OFF_CFG1: nxt_bresp = busy ? `MDIOSM_RESP_ERR : `MDIOSM_RESP_OK;
      `MDIOSM_OFF_TXD:  nxt_bresp = busy ? `MDIOSM_RESP_ERR : `MDIOSM_RESP_OK;
      `MDIOSM_OFF_RXD:  nxt_bresp = `MDIOSM_RESP_OK;
      default:          nxt_bresp = `MDIOSM_RESP_ERR;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `MDIOSM_RESP_OK;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= nxt_bresp;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Strobes are honoured on the lanes that hold each stored field; the initiate bit and the sent frame fields ignore them.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_ff <= `MDIOSM_DIV_RST;
      en_ff  <= 1'b0;
    end else if (do_write && aw_addr_ff == `MDIOSM_OFF_CFG0 &&
                 s_axi_wstrb[0]) begin
      div_ff <= w_data_ff[`MDIOSM_F_DIV];
      en_ff  <= w_data_ff[`MDIOSM_B_EN] &&
                (w_data_ff[`MDIOSM_F_DIV] != `MDIOSM_DIV_RST);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      op_ff  <= `MDIOSM_OP_ADDR;
      prt_ff <= '0;
      dev_ff <= '0;
    end else if (wr_cfg1 && !busy) begin
      if (s_axi_wstrb[1]) op_ff  <= w_data_ff[`MDIOSM_F_OP];
      if (s_axi_wstrb[2]) dev_ff <= w_data_ff[`MDIOSM_F_DEV];
      if (s_axi_wstrb[3]) prt_ff <= w_data_ff[`MDIOSM_F_PRT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txd_ff <= '0;
    end else if (do_write && !busy && aw_addr_ff == `MDIOSM_OFF_TXD) begin
      if (s_axi_wstrb[0]) txd_ff[7:0]  <= w_data_ff[7:0];
      if (s_axi_wstrb[1]) txd_ff[15:8] <= w_data_ff[15:8];
    end
  end

  // Read channel: one read at a time, answered the cycle after arvalid.
  assign s_axi_arready = !s_axi_rvalid;
  assign ar_addr = s_axi_araddr[`MDIOSM_ADDR_W-1:0];

  always_comb begin
    nxt_rdata = '0;
    nxt_rresp = `MDIOSM_RESP_OK;
    case (ar_addr)
      `MDIOSM_OFF_CFG0: begin
        nxt_rdata[`MDIOSM_F_DIV] = div_ff;
        nxt_rdata[`MDIOSM_B_EN]  = en_ff;
      end
      `MDIOSM_OFF_CFG1: begin
        nxt_rdata[`MDIOSM_F_PRT]  = prt_ff;
        nxt_rdata[`MDIOSM_F_DEV]  = dev_ff;
        nxt_rdata[`MDIOSM_F_OP]   = op_ff;
        nxt_rdata[`MDIOSM_B_INIT] = busy;
        nxt_rdata[`MDIOSM_B_RDY]  = !busy;
      end
      `MDIOSM_OFF_TXD: nxt_rdata[`MDIOSM_F_DATA] = txd_ff;
      `MDIOSM_OFF_RXD: nxt_rdata[`MDIOSM_F_DATA] = rxd_ff;
      default: nxt_rresp = `MDIOSM_RESP_ERR;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= `MDIOSM_RESP_OK;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= nxt_rdata;
      s_axi_rresp  <= nxt_rresp;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  mdiosm_clkdiv #(
    .DIV_W (6)
  ) u_clkdiv (
    .aclk    (aclk),
    .aresetn (aresetn),
    .en      (en_ff),
    .div     (div_ff),
    .mdc_ff  (mdc_int),
    .rise_ff (rise_p),
    .fall_ff (fall_p)
  );
  assign mdc = mdc_int;

  mdiosm_sync u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (mdio_i),
    .q       (mdio_sync)
  );

  // Bits leave on MDC falls so the PHY sees them stable at the rise.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= MDIOSM_IDLE;
      cnt_ff   <= '0;
      frame_ff <= '0;
    end else begin
      case (state_ff)
        MDIOSM_IDLE: begin
          if (start) begin
            state_ff <= MDIOSM_RUN;
            cnt_ff   <= '0;
            frame_ff <= {`MDIOSM_PREAMBLE, `MDIOSM_START,
                         w_data_ff[`MDIOSM_F_OP], w_data_ff[`MDIOSM_F_PRT],
                         w_data_ff[`MDIOSM_F_DEV], `MDIOSM_TA_DRIVE,
                         txd_ff};
          end
        end
        MDIOSM_RUN: begin
          if (fall_p) begin
            if (cnt_ff == `MDIOSM_FRAME_LEN) begin
              state_ff <= MDIOSM_DONE;
            end else begin
              frame_ff <= {frame_ff[62:0], 1'b0};
              cnt_ff   <= cnt_ff + 7'h01;
            end
          end
        end
        MDIOSM_DONE: state_ff <= MDIOSM_IDLE;
        default: state_ff <= MDIOSM_IDLE;
      endcase
    end
  end

  // Pin drive: enable is low while driving; read frames release from TA.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mdio_o   <= 1'b1;
      mdio_t_n <= 1'b1;
    end else if (state_ff == MDIOSM_RUN && fall_p &&
                 cnt_ff != `MDIOSM_FRAME_LEN) begin
      mdio_o   <= frame_ff[63];
      mdio_t_n <= is_read && (cnt_ff >= `MDIOSM_TA_CNT - 7'h01);
    end else if (state_ff != MDIOSM_RUN) begin
      mdio_o   <= 1'b1;
      mdio_t_n <= 1'b1;
    end
  end

  // Data bits of a read are taken at the MDC rise after each fall.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_sh_ff <= '0;
    end else if (state_ff == MDIOSM_RUN && rise_p && is_read &&
                 cnt_ff >= `MDIOSM_DATA_CNT) begin
      rx_sh_ff <= {rx_sh_ff[14:0], mdio_sync};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rxd_ff <= '0;
    end else if (state_ff == MDIOSM_DONE && is_read) begin
      rxd_ff <= rx_sh_ff;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic [6:0] half_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn || !en_ff || $changed(mdc_int)) half_ff <= '0;
    else half_ff <= half_ff + 7'h01;
  end

  sequence s_run_end;
    state_ff == MDIOSM_DONE ##1 state_ff == MDIOSM_IDLE;
  endsequence

  a_resp_codes: assert property (
    s_axi_bvalid |-> s_axi_bresp inside {`MDIOSM_RESP_OK, `MDIOSM_RESP_ERR})
    else $error("write response code illegal");
  a_unmapped_err: assert property (
    (s_axi_arvalid && !s_axi_rvalid && !(ar_addr inside {`MDIOSM_OFF_CFG0,
      `MDIOSM_OFF_CFG1, `MDIOSM_OFF_TXD, `MDIOSM_OFF_RXD}))
    |=> s_axi_rvalid && s_axi_rresp == `MDIOSM_RESP_ERR)
    else $error("unmapped read not refused");
  // The first toggle after enable is a rise, so falls see a full half period.
  a_mdc_half: assert property (
    (en_ff && $stable(div_ff) && $fell(mdc_int) && $past(en_ff, 2))
    |-> half_ff == {1'b0, div_ff})
    else $error("MDC half period wrong");
  a_div_gate: assert property (
    en_ff |-> div_ff != `MDIOSM_DIV_RST)
    else $error("enabled with zero divisor");
  a_start_ready: assert property (
    (state_ff == MDIOSM_IDLE && $past(state_ff) != MDIOSM_IDLE) or
    $rose(busy) |-> (busy -> $past(start && en_ff)))
    else $error("transaction began without initiate");
  a_preamble_ones: assert property (
    (state_ff == MDIOSM_RUN && fall_p && cnt_ff < `MDIOSM_PRE_LEN)
    |=> mdio_o && !mdio_t_n)
    else $error("preamble bit not driven high");
  a_read_release: assert property (
    (state_ff == MDIOSM_RUN && is_read && cnt_ff > `MDIOSM_TA_CNT) |-> mdio_t_n)
    else $error("read frame drives during data");
  a_write_drive: assert property (
    (state_ff == MDIOSM_RUN && !is_read && cnt_ff != 7'h00) |-> !mdio_t_n)
    else $error("write frame released the line");
  a_ready_back: assert property (
    s_run_end |-> !busy && cnt_ff == `MDIOSM_FRAME_LEN)
    else $error("ready did not return after frame");
  a_rx_capture: assert property (
    (state_ff == MDIOSM_DONE && is_read) |=> rxd_ff == $past(rx_sh_ff))
    else $error("read word not captured");
endmodule : mdiosm_top

// ===== inc/mdiosm_regs.svh
// Register map, field positions and frame constants of the MDIO station.
// Function
// - Every bus write or read answers OKAY on success, SLVERR on failure.
// - Only address bits 10:0 select a register; upper bits are ignored.
// - MDC runs at host clock divided by two times one plus divisor.
// - Divisor resets to zero; the station cannot be enabled while it is zero.
// - Writing initiate starts a transaction only when enabled and ready.
// - The data line is split into input, output and output enable.
// - Opcode 00 sends an address frame loading the PHY current address.
// - Opcode 01 sends a write frame with a 16-bit data word.
// - Opcode 11 sends a read frame; the returned word is captured.
// - Opcode 10 sends a read frame after which the PHY increments address.
// - Ready bit 7 is low while busy, high on completion; initiate bit 11 reads one while busy, zero when idle.
// - A finished read places the PHY word in the read result register.
`ifndef MDIOSM_REGS_SVH
`define MDIOSM_REGS_SVH
`define MDIOSM_ADDR_W    11
`define MDIOSM_OFF_CFG0  11'h500
`define MDIOSM_OFF_CFG1  11'h504
`define MDIOSM_OFF_TXD   11'h508
`define MDIOSM_OFF_RXD   11'h50c
`define MDIOSM_F_DIV     5:0
`define MDIOSM_B_EN      6
`define MDIOSM_B_RDY     7
`define MDIOSM_B_INIT    11
`define MDIOSM_F_OP      15:14
`define MDIOSM_F_DEV     20:16
`define MDIOSM_F_PRT     28:24
`define MDIOSM_F_DATA    15:0
`define MDIOSM_DIV_RST   6'h00
`define MDIOSM_RESP_OK   2'h0
`define MDIOSM_RESP_ERR  2'h2
`define MDIOSM_OP_ADDR   2'h0
`define MDIOSM_OP_WRITE  2'h1
`define MDIOSM_OP_RINC   2'h2
`define MDIOSM_OP_READ   2'h3
`define MDIOSM_PREAMBLE  32'hffff_ffff
`define MDIOSM_START     2'h0
`define MDIOSM_TA_DRIVE  2'h2
`define MDIOSM_PRE_LEN   7'h20
`define MDIOSM_TA_CNT    7'h2f
`define MDIOSM_DATA_CNT  7'h31
`define MDIOSM_FRAME_LEN 7'h40
`endif

// ===== inc/mdiosm_pkg.sv
// Types shared by the MDIO station modules.
package mdiosm_pkg;
  typedef logic [1:0] mdiosm_resp_t;
  typedef enum logic [1:0] {
    MDIOSM_IDLE,
    MDIOSM_RUN,
    MDIOSM_DONE
  } mdiosm_state_t;
endpackage : mdiosm_pkg

// ===== design/mdiosm_sync.sv
// Two-flop synchroniser for the management data input pin.
`timescale 1ns/1ps
module mdiosm_sync (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic d,
  output logic      q
);
  logic meta_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_ff <= 1'b1;
      q       <= 1'b1;
    end else begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end
endmodule : mdiosm_sync

// ===== design/mdiosm_clkdiv.sv
// Management clock divider with edge pulses aligned to MDC changes.
`timescale 1ns/1ps
module mdiosm_clkdiv #(
  parameter int DIV_W = 6
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             en,
  input  wire logic [DIV_W-1:0] div,
  output logic                  mdc_ff,
  output logic                  rise_ff,
  output logic                  fall_ff
);
  logic [DIV_W-1:0] cnt_ff;
  logic             wrap;

  // Each half period lasts div+1 host cycles.
  assign wrap = (cnt_ff == div);

  always_ff @(posedge aclk) begin
    if (!aresetn || !en) begin
      cnt_ff <= '0;
    end else if (wrap) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  // MDC parks low while disabled so the first edge after enable is a rise.
  always_ff @(posedge aclk) begin
    if (!aresetn || !en) begin
      mdc_ff  <= 1'b0;
      rise_ff <= 1'b0;
      fall_ff <= 1'b0;
    end else begin
      mdc_ff  <= wrap ? ~mdc_ff : mdc_ff;
      rise_ff <= wrap && !mdc_ff;
      fall_ff <= wrap && mdc_ff;
    end
  end
endmodule : mdiosm_clkdiv

// ===== testbench/mdiosm_phy_model.sv
// Behavioural PHY with a small register set answering on the MDIO wire.
`timescale 1ns/1ps
module mdiosm_phy_model #(
  parameter logic [4:0] PRTAD = 5'h07
) (
  input  wire logic   mdc,
  input  wire logic   mdio,
  output logic        drv_d,
  output logic        drv_oe,
  output int          cnt,
  output logic [63:0] frame,
  output logic [15:0] cur,
  output int          frames
);
  logic [15:0] mem [16];
  logic [63:0] shreg;
  logic [15:0] rd_word;
  logic        rd_op;
  int          ones;
  initial begin
    for (int i = 0; i < 16; i++) begin
      mem[i] = 16'ha500 + 16'(i);
    end
    cnt = 0;
    ones = 0;
    frames = 0;
    cur = 16'h0000;
    rd_op = 1'b0;
    drv_oe = 1'b0;
    drv_d = 1'b1;
    frame = 64'h0;
    shreg = 64'h0;
  end
  // The shifter keeps taking idle bits; frame holds the last whole frame.
  always @(posedge mdc) begin
    shreg = {shreg[62:0], mdio};
    if (cnt != 0) begin
      cnt++;
    end else if (mdio) begin
      ones = (ones < 99) ? ones + 1 : ones;
    end else begin
      // Idle ones also count, so only a short preamble is refused.
      cnt = (ones >= 32) ? 33 : 0;
      ones = 0;
    end
    if (cnt == 46) begin
      rd_op = shreg[11] && shreg[9:5] == PRTAD;
      rd_word = mem[cur[3:0]];
    end
    if (cnt == 64) begin
      frames++;
      cnt = 0;
      rd_op = 1'b0;
      frame = shreg;
      if (shreg[27:23] == PRTAD) begin
        case (shreg[29:28])
          2'h0: cur = shreg[15:0];
          2'h1: mem[cur[3:0]] = shreg[15:0];
          2'h2: cur = cur + 16'h0001;
          default: ;
        endcase
      end
    end
  end
  always @(negedge mdc) begin
    drv_oe = rd_op && cnt >= 47;
    drv_d = (cnt > 47) ? rd_word[63-cnt] : 1'b0;
  end
endmodule : mdiosm_phy_model

// ===== testbench/mdio_station_management_master_tb.sv
// Self-checking bench for the MDIO station behind its register bus.
`timescale 1ns/1ps
`include "mdiosm_regs.svh"
module mdio_station_management_master_tb;
  import mdiosm_pkg::*;
  logic               aclk = 1'b0;
  logic               aresetn = 1'b0;
  logic [31:0]        awaddr, wdata, araddr, rdata;
  logic [3:0]         wstrb;
  logic               awvalid, awready, wvalid, wready, bvalid, bready;
  logic               arvalid, arready, rvalid, rready;
  mdiosm_resp_t       bresp, rresp;
  logic               mdc, mdio_i, mdio_o, mdio_t_n, drv_d, drv_oe;
  logic [63:0]        pframe;
  logic [15:0]        pcur;
  int                 pcnt, pframes, fails, checks_done;
  logic [31:0]        d;
  logic [1:0]         r;
  always #12.5 aclk = ~aclk;
  // Released line floats high through the pull-up.
  assign mdio_i = !mdio_t_n ? mdio_o : (drv_oe ? drv_d : 1'b1);
  mdiosm_top u_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .mdc(mdc),
    .mdio_i(mdio_i), .mdio_o(mdio_o), .mdio_t_n(mdio_t_n));
  mdiosm_phy_model u_phy (.mdc(mdc), .mdio(mdio_i), .drv_d(drv_d),
    .drv_oe(drv_oe), .cnt(pcnt), .frame(pframe), .cur(pcur),
    .frames(pframes));
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    bit aw_ok;
    bit w_ok;
    aw_ok = 0;
    w_ok = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [31:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic run(input logic [31:0] v, input logic [15:0] x,
                     input logic tn);
    wr(`MDIOSM_OFF_CFG1, v);
    check(r, `MDIOSM_RESP_OK);
    rd(`MDIOSM_OFF_CFG1);
    check(d, v);
    wr(`MDIOSM_OFF_TXD, 32'h0000_5555);
    check(r, `MDIOSM_RESP_ERR);
    while (pcnt != 50) @(posedge aclk);
    check(mdio_t_n, tn);
    do rd(`MDIOSM_OFF_CFG1); while (d[7] !== 1'b1);
    check(d, (v & 32'hffff_f7ff) | 32'h80);
    check(pframe, {32'hffff_ffff, 2'b00, v[15:14], v[28:24], v[20:16],
                   2'b10, x});
  endtask : run
  task automatic t_reset;
    check({mdc, mdio_o, mdio_t_n}, 3'b011);
    rd(`MDIOSM_OFF_CFG0);
    check(d, 32'h0);
    rd(`MDIOSM_OFF_CFG1);
    check(d, 32'h80);
    wr(`MDIOSM_OFF_CFG0, 32'h40);
    rd(`MDIOSM_OFF_CFG0);
    check(d, 32'h0);
    $display("Test reset done");
  endtask : t_reset
  task automatic t_bus;
    rd(32'h0000_0000);
    check(r, `MDIOSM_RESP_ERR);
    wr(32'h0000_07fc, 32'h1);
    check(r, `MDIOSM_RESP_ERR);
    wr(32'h8000_0508, 32'h0000_beef);
    rd(32'hffff_f508);
    check({r, d}, {2'b00, 32'h0000_beef});
    $display("Test bus done");
  endtask : t_bus
  task automatic t_clock;
    time t0;
    // Divisor 7 gives 40 MHz / 16 = 2.5 MHz, the fastest legal rate.
    wr(`MDIOSM_OFF_CFG0, 32'h47);
    rd(`MDIOSM_OFF_CFG0);
    check(d, 32'h47);
    @(posedge mdc);
    t0 = $time;
    @(posedge mdc);
    check(($time - t0) / 25, 16);
    $display("Test clock done");
  endtask : t_clock
  task automatic t_frames;
    wr(`MDIOSM_OFF_TXD, 32'h19);
    run(32'h0705_0800, 16'h0019, 1'b0);
    check(pcur, 16'h0019);
    wr(`MDIOSM_OFF_TXD, 32'h1234);
    run(32'h0705_4800, 16'h1234, 1'b0);
    check(u_phy.mem[9], 16'h1234);
    run(32'h0705_c800, 16'h1234, 1'b1);
    rd(`MDIOSM_OFF_RXD);
    check(d, 32'h1234);
    run(32'h0705_8800, 16'h1234, 1'b1);
    run(32'h0705_8800, 16'ha50a, 1'b1);
    rd(`MDIOSM_OFF_RXD);
    check(d, 32'ha50a);
    check(pcur, 16'h001b);
    $display("Test frames done");
  endtask : t_frames
  task automatic t_refuse;
    int f;
    f = pframes;
    wr(`MDIOSM_OFF_CFG0, 32'h07);
    wr(`MDIOSM_OFF_CFG1, 32'h0705_0800);
    repeat (100) @(posedge aclk);
    rd(`MDIOSM_OFF_CFG1);
    check(d, 32'h0705_0080);
    check({mdc, pframes}, {1'b0, f});
    $display("Test refuse done");
  endtask : t_refuse
  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    {awaddr, wdata, araddr, awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hf;
    fails = 0;
    checks_done = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_bus;
    t_clock;
    t_frames;
    t_refuse;
    tally_and_finish;
  end
  initial begin
    // Five frames of about 1100 cycles each plus polling fit well inside.
    repeat (40000) @(posedge aclk);
    fails++;
    tally_and_finish;
  end
endmodule : mdio_station_management_master_tb
